//--- src/fac_pkg.sv
// constants shared by the flash accelerator files
package fac_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_MODE_CTRL = 32'he01f_c000;
  localparam logic [31:0] ADDR_FETCH_TIM = 32'he01f_c004;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int MODE_W = 2;
  localparam int TIM_W = 3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] TIM_RESET = 3'h7;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PARTIAL = 2'h1;
  localparam logic [1:0] MODE_FULL = 2'h2;
  localparam logic [2:0] TIM_MIN = 3'h1;

  // ----------------------------------------------------------------
  // holding latch geometry
  // ----------------------------------------------------------------
  localparam int LINE_W = 15;
  localparam int DATA_W = 128;
  localparam int WORD_W = 32;
  localparam int LINE_LSB = 4;
  localparam int WSEL_LSB = 2;
  localparam logic [1:0] LAT_PREFETCH = 2'h0;
  localparam logic [1:0] LAT_BRANCH = 2'h1;
  localparam logic [1:0] LAT_DATA = 2'h2;

endpackage : fac_pkg

//--- src/fac_latch.sv
// one 128-bit holding latch with its line tag and comparator
`timescale 1ns/1ps
`default_nettype none

module fac_latch (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill and invalidate
  input wire logic load,
  input wire logic [fac_pkg::LINE_W-1:0] load_line,
  input wire logic [fac_pkg::DATA_W-1:0] load_data,
  input wire logic inval,
  // lookup
  input wire logic [fac_pkg::LINE_W-1:0] look_line,
  input wire logic [1:0] word_sel,
  output logic hit,
  output logic [fac_pkg::WORD_W-1:0] word
);

  typedef struct packed {
    logic valid;
    logic [fac_pkg::LINE_W-1:0] line;
    logic [fac_pkg::DATA_W-1:0] data;
  } fac_latch_t;

  fac_latch_t st;
  fac_latch_t next_st;

  always_comb begin
    next_st = st;
    // invalidate wins so a fill racing a mode change is not kept
    if (inval) begin
      next_st.valid = 1'b0;
    end else if (load) begin
      next_st.valid = 1'b1;
      next_st.line = load_line;
      next_st.data = load_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hit = st.valid && (st.line == look_line);
  assign word = st.data[word_sel*fac_pkg::WORD_W +: fac_pkg::WORD_W];

endmodule : fac_latch
`default_nettype wire

//--- src/fac_fetch_timer.sv
// counts the programmed flash fetch duration
`timescale 1ns/1ps
`default_nettype none

module fac_fetch_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic [fac_pkg::TIM_W-1:0] cycles,
  // status
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [fac_pkg::TIM_W-1:0] cnt;
  } fac_timer_t;

  fac_timer_t st;
  fac_timer_t next_st;

  always_comb begin
    next_st = st;
    if (start) begin
      next_st.cnt = cycles;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = (st.cnt != '0);
  assign done = (st.cnt == 3'h1);

endmodule : fac_fetch_timer
`default_nettype wire

//--- src/fac_top.sv
// flash accelerator: mode and fetch timing registers, access control
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - reset comes up in disabled mode
// - mode writes accepted at any time
// - each register on its own word address
// - mode 00 off, 01 partial, 10 full
// - any mode change invalidates all latches
// - reserved bits not written ones, read undefined
// - flash fetch lasts programmed 1 to 7 cycles
// - timing resets to seven, mode to zero
// - one-cycle timing adds no wait
// - disabled mode: always flash read, no prefetch
// - partial: sequential instruction hits, prefetch enabled
// - full: any hit served from latch
// - forced read may use latch, keeps timing
module fac_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  // apb answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core fetch request
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_seq,
  input wire logic req_is_data,
  // core answer
  output logic core_clock_enable,
  output logic resp_valid,
  output logic [31:0] resp_data,
  // flash bank
  output logic flash_req,
  output logic [fac_pkg::LINE_W-1:0] flash_line,
  input wire logic [fac_pkg::DATA_W-1:0] flash_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FAC_IDLE,
    FAC_HIT,
    FAC_FETCH,
    FAC_PREFETCH
  } fac_fsm_t;

  // all state of the block but the latches and the timer; outputs are read straight from here
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] timing;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    fac_fsm_t fsm;
    logic [1:0] target;
    logic use_latch;
    logic [fac_pkg::LINE_W-1:0] line;
    logic [1:0] wsel;
    logic core_clock_enable;
    logic resp_valid;
    logic [31:0] resp_data;
    logic flash_req;
    logic pf_pending;
    logic [fac_pkg::LINE_W-1:0] pf_line;
    logic [fac_pkg::LINE_W-1:0] flash_line;
  } fac_state_t;

  fac_state_t st;
  fac_state_t next_st;

  // reserved timing code behaves as the shortest fetch
  function automatic logic [2:0] fetch_cycles(input logic [2:0] tim);
    fetch_cycles = (tim == 3'h0) ? fac_pkg::TIM_MIN : tim;
  endfunction : fetch_cycles

  // every mode but off may hand out a latched word, at flash timing
  function automatic logic latch_allowed(input logic [1:0] mode);
    latch_allowed = (mode != fac_pkg::MODE_OFF);
  endfunction : latch_allowed

  // prefetch runs in partial and full mode only
  function automatic logic prefetch_on(input logic [1:0] mode);
    prefetch_on = (mode == fac_pkg::MODE_PARTIAL) ||
                  (mode == fac_pkg::MODE_FULL);
  endfunction : prefetch_on

  // ----------------------------------------------------------------
  // holding latches
  // ----------------------------------------------------------------
  logic [fac_pkg::LINE_W-1:0] req_line;
  logic [1:0] req_wsel;
  logic [fac_pkg::LINE_W-1:0] look_line;
  logic [1:0] look_wsel;
  logic [2:0] hit;
  logic [2:0] load;
  logic [fac_pkg::WORD_W-1:0] word [3];
  logic [fac_pkg::LINE_W-1:0] fill_line;
  logic mode_change;
  logic tim_start;
  logic [2:0] tim_cycles;
  logic tim_busy;
  logic tim_done;

  assign req_line = req_addr[fac_pkg::LINE_LSB +: fac_pkg::LINE_W];
  assign req_wsel = req_addr[fac_pkg::WSEL_LSB +: 2];
  // lookups follow the live request while idle, the held one after
  assign look_line = (st.fsm == FAC_IDLE) ? req_line : st.line;
  assign look_wsel = (st.fsm == FAC_IDLE) ? req_wsel : st.wsel;
  assign fill_line = (st.fsm == FAC_PREFETCH) ? st.pf_line : st.line;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_lat
      fac_latch u_latch (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(load[gi]),
        .load_line(fill_line),
        .load_data(flash_rdata),
        .inval(mode_change),
        .look_line(look_line),
        .word_sel(look_wsel),
        .hit(hit[gi]),
        .word(word[gi])
      );
    end
  endgenerate

  // one timer serves fetches and prefetches; they never overlap
  fac_fetch_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(tim_start),
    .cycles(tim_cycles),
    .busy(tim_busy),
    .done(tim_done)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic apb_access;
  logic apb_commit;
  logic sel_mode;
  logic sel_tim;

  // an unmapped address answers with an error and writes nothing
  assign apb_access = psel && penable;
  assign apb_commit = apb_access && st.pready;
  assign sel_mode = (paddr == fac_pkg::ADDR_MODE_CTRL);
  assign sel_tim = (paddr == fac_pkg::ADDR_FETCH_TIM);
  // only a real change of mode flushes; rewriting the same mode keeps hits
  assign mode_change = apb_commit && pwrite && sel_mode &&
                       (pwdata[1:0] != st.mode);

  // ----------------------------------------------------------------
  // request classification
  // ----------------------------------------------------------------
  logic instr_hit;
  logic data_hit;
  logic serve_latch;
  logic any_hit;
  logic [31:0] hit_word;
  logic [1:0] fill_target;
  logic forced_latch;

  assign instr_hit = !req_is_data && (hit[0] || hit[1]);
  assign data_hit = req_is_data && hit[2];
  assign any_hit = instr_hit || data_hit;
  assign hit_word = req_is_data ? word[2] : (hit[0] ? word[0] : word[1]);
  // forced read of latched data: keep timing, skip the flash
  assign forced_latch = any_hit && latch_allowed(st.mode);

  always_comb begin
    case (st.mode)
      fac_pkg::MODE_PARTIAL: serve_latch = instr_hit && req_seq;
      fac_pkg::MODE_FULL: serve_latch = any_hit;
      default: serve_latch = 1'b0;
    endcase
  end

  always_comb begin
    if (req_is_data) begin
      fill_target = fac_pkg::LAT_DATA;
    end else if (req_seq) begin
      fill_target = fac_pkg::LAT_PREFETCH;
    end else begin
      fill_target = fac_pkg::LAT_BRANCH;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    tim_start = 1'b0;
    tim_cycles = fetch_cycles(st.timing);
    load = 3'h0;
    next_st.resp_valid = 1'b0;

    // register slave: one wait state, write lands at the ready edge
    next_st.pready = 1'b0;
    if (apb_access && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !(sel_mode || sel_tim);
      next_st.prdata = 32'h0000_0000;
      if (sel_mode) begin
        next_st.prdata[1:0] = st.mode;
      end else if (sel_tim) begin
        next_st.prdata[2:0] = st.timing;
      end
    end
    if (apb_commit && pwrite) begin
      // accepted at any moment, even mid-fetch
      if (sel_mode) begin
        next_st.mode = pwdata[1:0];
        next_st.pf_pending = 1'b0;
      end
      if (sel_tim) begin
        next_st.timing = pwdata[2:0];
      end
    end
    if (apb_commit) begin
      next_st.pslverr = 1'b0;
    end

    case (st.fsm)
      FAC_IDLE: begin
        next_st.core_clock_enable = 1'b1;
        // the core still shows its last request in the answer cycle
        if (req_valid && !st.resp_valid) begin
          next_st.line = req_line;
          next_st.wsel = req_wsel;
          next_st.target = fill_target;
          next_st.core_clock_enable = 1'b0;
          if (serve_latch) begin
            next_st.fsm = FAC_HIT;
            next_st.resp_data = hit_word;
          end else begin
            next_st.use_latch = forced_latch;
            next_st.resp_data = hit_word;
            next_st.flash_req = !forced_latch;
            next_st.fsm = FAC_FETCH;
            tim_start = 1'b1;
          end
        end else if (st.pf_pending && !mode_change) begin
          next_st.fsm = FAC_PREFETCH;
          next_st.flash_req = 1'b1;
          next_st.core_clock_enable = 1'b0;
          tim_start = 1'b1;
        end
      end
      // latched word goes out the cycle after this one, two cycles after the request
      FAC_HIT: begin
        next_st.fsm = FAC_IDLE;
        next_st.resp_valid = 1'b1;
        next_st.core_clock_enable = 1'b1;
      end
      FAC_FETCH: begin
        // an idle timer also ends the wait, so no fetch can hang
        if (tim_done || !tim_busy) begin
          next_st.fsm = FAC_IDLE;
          next_st.flash_req = 1'b0;
          next_st.use_latch = 1'b0;
          next_st.resp_valid = 1'b1;
          next_st.core_clock_enable = 1'b1;
          if (!st.use_latch) begin
            next_st.resp_data = flash_rdata[st.wsel*32 +: 32];
            load[st.target] = 1'b1;
          end
        end
      end
      FAC_PREFETCH: begin
        if (tim_done || !tim_busy) begin
          next_st.fsm = FAC_IDLE;
          next_st.flash_req = 1'b0;
          next_st.pf_pending = 1'b0;
          next_st.core_clock_enable = 1'b1;
          load[fac_pkg::LAT_PREFETCH] = 1'b1;
        end
      end
      default: begin
        next_st.fsm = FAC_IDLE;
      end
    endcase

    // after an instruction answer, fetch the following line ahead
    if (next_st.resp_valid && st.target != fac_pkg::LAT_DATA &&
        prefetch_on(st.mode) && !mode_change) begin
      next_st.pf_pending = 1'b1;
      next_st.pf_line = st.line + 15'h0001;
    end
    // a running prefetch finishes; the line it brings is fresh
    if (mode_change && st.fsm != FAC_PREFETCH) begin
      next_st.pf_pending = 1'b0;
    end
    // the flash address leaves a flop, as every output does
    next_st.flash_line = (next_st.fsm == FAC_PREFETCH) ? next_st.pf_line :
                         next_st.line;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // off, seven-cycle fetch, core running
      st <= '0;
      st.mode <= fac_pkg::MODE_RESET;
      st.timing <= fac_pkg::TIM_RESET;
      st.fsm <= FAC_IDLE;
      st.core_clock_enable <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign core_clock_enable = st.core_clock_enable;
  assign resp_valid = st.resp_valid;
  assign resp_data = st.resp_data;
  assign flash_req = st.flash_req;
  assign flash_line = st.flash_line;

endmodule : fac_top
`default_nettype wire

//--- bench/fac_top_props.sv
// concurrent checks on the flash accelerator ports
`timescale 1ns/1ps
`default_nettype none

module fac_top_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core and flash
  input wire logic req_valid,
  input wire logic core_clock_enable,
  input wire logic resp_valid,
  input wire logic flash_req,
  input wire logic [fac_pkg::LINE_W-1:0] flash_line
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] mode;
  logic [2:0] tim;
  logic [3:0] cnt;
  logic [fac_pkg::LINE_W-1:0] ln;
  logic done;
  logic hm;
  logic ht;
  assign done = psel && penable && pready;
  assign hm = paddr == fac_pkg::ADDR_MODE_CTRL;
  assign ht = paddr == fac_pkg::ADDR_FETCH_TIM;
  // shadows of the writes; cnt restarts on a new line so that a
  // prefetch following a fetch at once is timed on its own
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= fac_pkg::MODE_RESET;
      tim <= fac_pkg::TIM_RESET;
      cnt <= 4'h0;
      ln <= '0;
    end else begin
      if (done && pwrite && hm) mode <= pwdata[1:0];
      if (done && pwrite && ht) tim <= pwdata[2:0];
      ln <= flash_line;
      cnt <= !flash_req ? 4'h0 :
             (cnt != 4'h0 && flash_line == ln) ? cnt + 4'h1 : 4'h1;
    end
  end
  sequence s_acc_open;
    psel && penable && !$past(penable);
  endsequence
  sequence s_fetch_end;
    cnt != 4'h0 && (!flash_req || flash_line != ln);
  endsequence
  chk_apb_wait: assert property (s_acc_open |-> !pready ##1 pready)
    else $error("apb answer not after one wait");
  chk_addr_err: assert property (done |-> pslverr == !(hm || ht))
    else $error("error flag wrong for address");
  chk_mode_read: assert property (
    done && !pwrite && hm |-> prdata == {30'h0, mode})
    else $error("mode read back wrong");
  chk_tim_read: assert property (
    done && !pwrite && ht |-> prdata == {29'h0, tim})
    else $error("timing read back wrong");
  chk_fetch_len: assert property (s_fetch_end |->
    cnt == ((tim == 3'h0) ? 4'h1 : {1'b0, tim}))
    else $error("fetch length differs from timing");
  chk_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("answer longer than one cycle");
  chk_cce_answer: assert property (resp_valid |-> core_clock_enable)
    else $error("core still held at answer");
  chk_cce_fetch: assert property (flash_req |-> !core_clock_enable)
    else $error("core runs during fetch");
  chk_cce_bound: assert property (
    $fell(core_clock_enable) |-> ##[1:24] core_clock_enable)
    else $error("core held too long");
  chk_off_noprefetch: assert property (
    $rose(flash_req) && mode == fac_pkg::MODE_OFF |-> $past(req_valid))
    else $error("fetch without request when off");
  chk_off_fetch: assert property (
    resp_valid && mode == fac_pkg::MODE_OFF |-> $past(flash_req))
    else $error("answer without flash read when off");
endmodule : fac_top_props

bind fac_top fac_top_props chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
  .core_clock_enable(core_clock_enable), .resp_valid(resp_valid),
  .flash_req(flash_req), .flash_line(flash_line)
);

`default_nettype wire

//--- bench/fac_flash_model.sv
// flash bank model: a line pattern while fetched, noise otherwise
`timescale 1ns/1ps
`default_nettype none

module fac_flash_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // flash bank
  input wire logic flash_req,
  input wire logic [fac_pkg::LINE_W-1:0] flash_line,
  output logic [fac_pkg::DATA_W-1:0] flash_rdata
);
  logic [31:0] junk;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) junk <= 32'h5a5a_0f0f;
    else junk <= ~junk + 32'h0000_0013;
  end
  // a stale line outside a fetch would hide a late sample
  always_comb begin
    for (int w = 0; w < 4; w++) begin
      flash_rdata[w*32 +: 32] = flash_req ?
        {2'b10, flash_line, 13'h0000, 2'(w)} : junk;
    end
  end
endmodule : fac_flash_model

`default_nettype wire

//--- bench/flash_accel_config_test.sv
// self-checking bench for the flash accelerator
`timescale 1ns/1ps
`default_nettype none

module flash_accel_config_test;
  localparam logic [31:0] A_MODE = fac_pkg::ADDR_MODE_CTRL;
  localparam logic [31:0] A_TIM = fac_pkg::ADDR_FETCH_TIM;
  logic ref_clk = 1'b0, rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, a;
  logic req_valid = 1'b0, req_seq = 1'b0, req_is_data = 1'b0;
  logic [31:0] req_addr = 32'h0, resp_data;
  logic core_clock_enable, resp_valid, flash_req;
  logic [fac_pkg::LINE_W-1:0] flash_line;
  logic [fac_pkg::DATA_W-1:0] flash_rdata;
  int bad_count = 0, comparisons = 0, cyc = 0, mode = 0, tim = 7;
  int dline = -1;
  integer seed = 32'h1ae5_b781;

  fac_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_addr(req_addr), .req_seq(req_seq),
    .req_is_data(req_is_data), .core_clock_enable(core_clock_enable),
    .resp_valid(resp_valid), .resp_data(resp_data),
    .flash_req(flash_req), .flash_line(flash_line),
    .flash_rdata(flash_rdata));
  fac_flash_model flash (.ref_clk(ref_clk), .rst_n(rst_n),
    .flash_req(flash_req), .flash_line(flash_line),
    .flash_rdata(flash_rdata));

  initial forever #2 ref_clk = ~ref_clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [31:0] ad, d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] ad, d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ad, d, r, e);
    check({31'h0, e}, {31'h0, ad != A_MODE && ad != A_TIM});
    if (ad == A_MODE && int'(d[1:0]) != mode) dline = -1;
    if (ad == A_MODE) mode = int'(d[1:0]);
    if (ad == A_TIM) tim = int'(d[2:0]);
  endtask : wr

  task automatic rd(input logic [31:0] ad, x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, ad, 32'h0, r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask : rd

  // reference latency; 0 where a prefetch may delay the answer
  function automatic int mlat(logic [31:0] ad, logic dat);
    int t, ln;
    t = (tim == 0) ? 1 : tim;
    ln = int'(ad[18:4]);
    if (!dat) return (mode == 0 || mode == 3) ? t : 0;
    if (mode == 2 && dline == ln) return 1;
    if (mode == 2) dline = ln;
    return t;
  endfunction : mlat

  task automatic core(input logic [31:0] ad, input logic dat, sq);
    int n, lat;
    lat = mlat(ad, dat);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_addr <= ad;
    req_is_data <= dat;
    req_seq <= sq;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (resp_valid !== 1'b1);
    req_valid <= 1'b0;
    check(resp_data, {2'b10, ad[18:4], 13'h0000, ad[3:2]});
    check({31'h0, core_clock_enable}, 32'h0000_0001);
    if (lat > 0) check(32'(n), 32'(lat + 2));
  endtask : core

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(A_MODE, 32'h0, 1'b0);
    rd(A_TIM, 32'h7, 1'b0);
    rd(32'he01f_c008, 32'h0, 1'b1);
    wr(32'he01f_c008, 32'h1);
    wr(A_TIM, 32'h5);
    rd(A_MODE, 32'h0, 1'b0);
    rd(A_TIM, 32'h5, 1'b0);
    $display("finished registers");
    for (int t = 0; t < 8; t++) begin
      wr(A_TIM, 32'(t));
      core($random(seed) & 32'h0007_fffc, 1'b1, 1'b0);
      core($random(seed) & 32'h0007_fffc, 1'b0, 1'b0);
    end
    $display("finished timing sweep");
    wr(A_TIM, 32'h3);
    wr(A_MODE, 32'h2);
    a = $random(seed) & 32'h0007_fff0;
    core(a, 1'b1, 1'b0);
    core(a + 32'h4, 1'b1, 1'b1);
    core(a + 32'hc, 1'b1, 1'b0);
    wr(A_MODE, 32'h1);
    core(a, 1'b1, 1'b0);
    core(a + 32'h8, 1'b1, 1'b1);
    wr(A_MODE, 32'h2);
    core(a, 1'b1, 1'b0);
    wr(A_MODE, 32'h2);
    core(a + 32'h4, 1'b1, 1'b0);
    $display("finished data modes");
    a = $random(seed) & 32'h0007_fff0;
    core(a, 1'b0, 1'b0);
    core(a + 32'h10, 1'b0, 1'b1);
    core(a, 1'b0, 1'b0);
    repeat (12) @(posedge ref_clk);
    wr(A_MODE, 32'h1);
    core(a + 32'h20, 1'b0, 1'b0);
    core(a + 32'h24, 1'b0, 1'b1);
    core(a + 32'h30, 1'b0, 1'b1);
    repeat (12) @(posedge ref_clk);
    wr(A_MODE, 32'h3);
    core(a + 32'h30, 1'b0, 1'b1);
    wr(A_MODE, 32'h0);
    rd(A_MODE, 32'h0, 1'b0);
    $display("finished instruction modes");
    conclude();
  end
endmodule : flash_accel_config_test

`default_nettype wire
